// ---- axil_slave.sv ----
// Purpose: AXI4-Lite slave write front end producing write strobes, address, data and byte strobes.
// Assumes: One write and one read outstanding at most.
// Notes:   Write answers one cycle after both address and data are held.
`timescale 1ns/1ps
module axil_slave (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic        bvalid,
  input  wire logic        bready,
  reg_wr_if.slave          wr
);

  logic        awHeld;
  logic        wHeld;
  logic [11:0] awLatch;
  logic [31:0] wLatch;
  logic [3:0]  sLatch;

  assign awready = !awHeld && !bvalid;
  assign wready  = !wHeld && !bvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
    end else if (awHeld && wHeld) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
    end else begin
      if (awvalid && awready) awHeld <= 1'b1;
      if (wvalid && wready) wHeld <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      awLatch <= 12'h000;
      wLatch  <= 32'h0000_0000;
      sLatch  <= 4'h0;
    end else begin
      if (awvalid && awready) awLatch <= awaddr;
      if (wvalid && wready) begin
        wLatch <= wdata;
        sLatch <= wstrb;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      bvalid <= 1'b0;
    end else if (awHeld && wHeld) begin
      bvalid <= 1'b1;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  assign wr.wrStrobe = awHeld && wHeld;
  assign wr.wrAddr   = awLatch;
  assign wr.wrData   = wLatch;
  assign wr.wrStrb   = sLatch;

endmodule : axil_slave

// ---- irq_gate_pkg.sv ----
// Purpose: Shared constants for the serial flash interrupt signal gate.
// Assumes: 32-bit AXI4-Lite register bus, one clock.
// Notes:   Offsets are byte addresses.
package irq_gate_pkg;

  localparam int          NUM_EVENTS  = 12;
  localparam logic [11:0] ENABLE_OFF  = 12'h000;
  localparam logic [11:0] STATUS_OFF  = 12'h004;
  localparam logic [11:0] MASK_OFF    = 12'h008;
  localparam logic [11:0] LEVEL_OFF   = 12'h00c;
  localparam logic [11:0] ENABLE_RST  = 12'h000;
  localparam logic [11:0] MASK_RST    = 12'h000;

  localparam int TX_EMPTY_BIT   = 0;
  localparam int TX_FULL_BIT    = 1;
  localparam int TX_THR_BIT     = 2;
  localparam int RX_EMPTY_BIT   = 3;
  localparam int RX_FULL_BIT    = 4;
  localparam int RX_THR_BIT     = 5;
  localparam int CTRL_FULL_BIT  = 6;
  localparam int CTRL_EMPTY_BIT = 7;
  localparam int CTRL_THR_BIT   = 8;
  localparam int DESC_DONE_BIT  = 9;
  localparam int PKT_DONE_BIT   = 10;
  localparam int DMA_ERR_BIT    = 11;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : irq_gate_pkg

// ---- irq_sink.sv ----
// Purpose: Processor-side interrupt controller model for the gated line.
// Assumes: Level request on the same clock.
// Notes:   Counts every rise of the request as one taken interrupt.
`timescale 1ns/1ps
module irq_sink (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       irqLine,
  output      logic [7:0] raiseCount
);
  logic lastLevel;
  always_ff @(posedge clk) begin
    if (reset) begin
      lastLevel  <= 1'b0;
      raiseCount <= 8'h00;
    end else begin
      lastLevel <= irqLine;
      if (irqLine && !lastLevel) begin
        raiseCount <= raiseCount + 8'h01;
      end
    end
  end
endmodule : irq_sink

// ---- quad_spi_interrupt_signal_gate.sv ----
// Purpose: Per-source interrupt signal gating for a quad serial flash controller.
// Assumes: Events are levels on clk from the controller's own logic.
// Notes:   Enable register gates live conditions; status, mask and level registers added.
`timescale 1ns/1ps
module quad_spi_interrupt_signal_gate #(
  parameter int NUM_EVENTS = irq_gate_pkg::NUM_EVENTS
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output      logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output      logic        wready,
  output      logic [1:0]  bresp,
  output      logic        bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output      logic        arready,
  output      logic [31:0] rdata,
  output      logic [1:0]  rresp,
  output      logic        rvalid,
  input  wire logic        rready,
  input  wire logic        txEmpty,
  input  wire logic        txFull,
  input  wire logic        txThreshold,
  input  wire logic        rxEmpty,
  input  wire logic        rxFull,
  input  wire logic        rxThreshold,
  input  wire logic        ctrlFull,
  input  wire logic        ctrlEmpty,
  input  wire logic        ctrlThreshold,
  input  wire logic        descriptorDone,
  input  wire logic        packetDone,
  input  wire logic        dmaBusError,
  output      logic        moduleIrq,
  output      logic        statusIrq
);

  if (NUM_EVENTS != irq_gate_pkg::NUM_EVENTS) begin : g_event_count_check
    $error("quad_spi_interrupt_signal_gate supports 12 events only");
  end

  reg_wr_if wr ();

  logic [11:0] sigEnable;
  logic [11:0] status;
  logic [11:0] mask;
  logic [11:0] events;
  logic [11:0] gated;
  logic [11:0] eventsPrev;
  logic        wrIsEnable;
  logic        wrIsStatus;
  logic        wrIsMask;
  logic [1:0]  wrResp;

  function automatic logic [11:0] strobeMerge(input logic [11:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [11:0] res;
    res = old;
    if (strb[0]) res[7:0] = data[7:0];
    if (strb[1]) res[11:8] = data[11:8];
    return res;
  endfunction : strobeMerge

  function automatic logic [11:0] strobeMask(input logic [3:0] strb);
    return {{4{strb[1]}}, {8{strb[0]}}};
  endfunction : strobeMask

  axil_slave u_axil_slave (
    .clk     (clk),
    .reset   (reset),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bvalid  (bvalid),
    .bready  (bready),
    .wr      (wr)
  );

  // Event vector in enable-register bit order.
  always_comb begin
    events = 12'h000;
    events[irq_gate_pkg::DMA_ERR_BIT]    = dmaBusError;
    events[irq_gate_pkg::PKT_DONE_BIT]   = packetDone;
    events[irq_gate_pkg::DESC_DONE_BIT]  = descriptorDone;
    events[irq_gate_pkg::CTRL_THR_BIT]   = ctrlThreshold;
    events[irq_gate_pkg::CTRL_EMPTY_BIT] = ctrlEmpty;
    events[irq_gate_pkg::CTRL_FULL_BIT]  = ctrlFull;
    events[irq_gate_pkg::RX_THR_BIT]     = rxThreshold;
    events[irq_gate_pkg::RX_FULL_BIT]    = rxFull;
    events[irq_gate_pkg::RX_EMPTY_BIT]   = rxEmpty;
    events[irq_gate_pkg::TX_THR_BIT]     = txThreshold;
    events[irq_gate_pkg::TX_FULL_BIT]    = txFull;
    events[irq_gate_pkg::TX_EMPTY_BIT]   = txEmpty;
  end

  assign gated = events & sigEnable;

  assign wrIsEnable = wr.wrStrobe && (wr.wrAddr == irq_gate_pkg::ENABLE_OFF);
  assign wrIsStatus = wr.wrStrobe && (wr.wrAddr == irq_gate_pkg::STATUS_OFF);
  assign wrIsMask   = wr.wrStrobe && (wr.wrAddr == irq_gate_pkg::MASK_OFF);

  // Only bits 11:0 are stored, so upper written bits vanish.
  always_ff @(posedge clk) begin
    if (reset) begin
      sigEnable <= irq_gate_pkg::ENABLE_RST;
    end else if (wrIsEnable) begin
      sigEnable <= strobeMerge(sigEnable, wr.wrData, wr.wrStrb);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask <= irq_gate_pkg::MASK_RST;
    end else if (wrIsMask) begin
      mask <= strobeMerge(mask, wr.wrData, wr.wrStrb);
    end
  end

  // Rising edges of gated events latch; a new edge beats a write-one clear.
  always_ff @(posedge clk) begin
    if (reset) begin
      eventsPrev <= 12'h000;
    end else begin
      eventsPrev <= gated;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status <= 12'h000;
    end else begin
      status <= (status & ~(wrIsStatus ? (wr.wrData[11:0] & strobeMask(wr.wrStrb)) : 12'h000))
                | (gated & ~eventsPrev);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrResp <= irq_gate_pkg::RESP_OKAY;
    end else if (wr.wrStrobe) begin
      wrResp <= (wrIsEnable || wrIsStatus || wrIsMask || wr.wrAddr == irq_gate_pkg::LEVEL_OFF)
                ? irq_gate_pkg::RESP_OKAY : irq_gate_pkg::RESP_SLVERR;
    end
  end

  assign bresp = wrResp;

  always_ff @(posedge clk) begin
    if (reset) begin
      moduleIrq <= 1'b0;
    end else begin
      moduleIrq <= |gated;
    end
  end

  assign statusIrq = |(status & mask);

  // Read channel: one cycle from address accept to data.
  assign arready = !rvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= irq_gate_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= irq_gate_pkg::RESP_OKAY;
      case (araddr)
        irq_gate_pkg::ENABLE_OFF: rdata <= {20'h00000, sigEnable};
        irq_gate_pkg::STATUS_OFF: rdata <= {20'h00000, status};
        irq_gate_pkg::MASK_OFF:   rdata <= {20'h00000, mask};
        irq_gate_pkg::LEVEL_OFF:  rdata <= {20'h00000, events};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= irq_gate_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  a_irq_follows_gate: assert property (@(posedge clk) disable iff (reset)
    ##1 (moduleIrq == |$past(events & sigEnable)))
    else $error("irq does not follow gated events");

  a_disabled_blocked: assert property (@(posedge clk) disable iff (reset)
    (sigEnable == 12'h000) |=> !moduleIrq)
    else $error("irq raised with all enables clear");

  a_dma_err_gate: assert property (@(posedge clk) disable iff (reset)
    (dmaBusError && sigEnable[11]) |=> moduleIrq)
    else $error("dma error not passed");

  a_pkt_done_gate: assert property (@(posedge clk) disable iff (reset)
    (packetDone && sigEnable[10]) |=> moduleIrq)
    else $error("packet done not passed");

  a_desc_done_gate: assert property (@(posedge clk) disable iff (reset)
    (descriptorDone && sigEnable[9]) |=> moduleIrq)
    else $error("descriptor done not passed");

  a_ctrl_thr_gate: assert property (@(posedge clk) disable iff (reset)
    (ctrlThreshold && sigEnable[8]) |=> moduleIrq)
    else $error("control threshold not passed");

  a_ctrl_empty_gate: assert property (@(posedge clk) disable iff (reset)
    (ctrlEmpty && sigEnable[7]) |=> moduleIrq)
    else $error("control empty not passed");

  a_ctrl_full_gate: assert property (@(posedge clk) disable iff (reset)
    (ctrlFull && sigEnable[6]) |=> moduleIrq)
    else $error("control full not passed");

  a_rx_thr_gate: assert property (@(posedge clk) disable iff (reset)
    (rxThreshold && sigEnable[5]) |=> moduleIrq)
    else $error("rx threshold not passed");

  a_rx_full_gate: assert property (@(posedge clk) disable iff (reset)
    (rxFull && sigEnable[4]) |=> moduleIrq)
    else $error("rx full not passed");

  a_rx_empty_gate: assert property (@(posedge clk) disable iff (reset)
    (rxEmpty && sigEnable[3]) |=> moduleIrq)
    else $error("rx empty not passed");

  a_tx_thr_gate: assert property (@(posedge clk) disable iff (reset)
    (txThreshold && sigEnable[2]) |=> moduleIrq)
    else $error("tx threshold not passed");

  a_tx_full_gate: assert property (@(posedge clk) disable iff (reset)
    (txFull && sigEnable[1]) |=> moduleIrq)
    else $error("tx full not passed");

  a_tx_empty_gate: assert property (@(posedge clk) disable iff (reset)
    (txEmpty && sigEnable[0]) |=> moduleIrq)
    else $error("tx empty not passed");

  a_enable_write: assert property (@(posedge clk) disable iff (reset)
    (wrIsEnable && wr.wrStrb == 4'hf) |=> (sigEnable == $past(wr.wrData[11:0])))
    else $error("enable write not stored");

  a_enable_reset: assert property (@(posedge clk)
    reset |=> (sigEnable == 12'h000))
    else $error("enable not cleared by reset");

  a_read_upper_zero: assert property (@(posedge clk) disable iff (reset)
    rvalid |-> (rdata[31:12] == 20'h00000))
    else $error("upper read bits not zero");

  // A new rising edge must land in status even when a clear write meets it.
  a_status_set_wins: assert property (@(posedge clk) disable iff (reset)
    (|(gated & ~eventsPrev)) |=>
      ((status & $past(gated & ~eventsPrev)) == $past(gated & ~eventsPrev)))
    else $error("status bit lost its set");

  a_status_clear: assert property (@(posedge clk) disable iff (reset)
    (wrIsStatus && wr.wrStrb == 4'hf && !(|(gated & ~eventsPrev))) |=>
      ((status & $past(wr.wrData[11:0])) == 12'h000))
    else $error("status bit not cleared by write");

  a_mask_write: assert property (@(posedge clk) disable iff (reset)
    (wrIsMask && wr.wrStrb == 4'hf) |=> (mask == $past(wr.wrData[11:0])))
    else $error("mask write not stored");

  a_other_write_keeps: assert property (@(posedge clk) disable iff (reset)
    !wrIsEnable |=> $stable(sigEnable))
    else $error("enable changed without an enable write");

  a_write_answer: assert property (@(posedge clk) disable iff (reset)
    wr.wrStrobe |=> bvalid)
    else $error("write not answered");

  a_read_answer: assert property (@(posedge clk) disable iff (reset)
    (arvalid && arready) |=> rvalid)
    else $error("read not answered");

  a_busy_refuses: assert property (@(posedge clk) disable iff (reset)
    bvalid |-> (!awready && !wready))
    else $error("write channel open while answer pending");

endmodule : quad_spi_interrupt_signal_gate

// ---- reg_wr_if.sv ----
// Purpose: Carries one accepted register write from the bus slave.
// Assumes: Single clock domain.
// Notes:   Strobe is a one-cycle pulse.
`timescale 1ns/1ps
interface reg_wr_if;
  logic        wrStrobe;
  logic [11:0] wrAddr;
  logic [31:0] wrData;
  logic [3:0]  wrStrb;
  modport slave (output wrStrobe, output wrAddr, output wrData, output wrStrb);
  modport regs  (input wrStrobe, input wrAddr, input wrData, input wrStrb);
endinterface : reg_wr_if

// ---- tb.sv ----
// Purpose: Self-checking bench for the interrupt signal gate.
// Assumes: Register bus answers come in bounded time.
// Notes:   Bus answers are sampled at the falling edge, where they are settled.
`timescale 1ns/1ps
module tb;
  logic        clk     = 1'b0;
  logic        reset   = 1'b1;
  logic [11:0] awaddr  = 12'h000;
  logic [11:0] araddr  = 12'h000;
  logic [31:0] wdata   = 32'h0;
  logic [3:0]  wstrb   = 4'h0;
  logic [3:0]  wrStrbSel = 4'hf;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic [11:0] ev      = 12'h000;
  logic        awready, wready, bvalid, arready, rvalid, moduleIrq, statusIrq;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0]  raiseCount, base;
  int          failures = 0;
  int          checks   = 0;

  always #12.5 clk = ~clk;

  quad_spi_interrupt_signal_gate dut (
    .clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .txEmpty(ev[irq_gate_pkg::TX_EMPTY_BIT]), .txFull(ev[irq_gate_pkg::TX_FULL_BIT]),
    .txThreshold(ev[irq_gate_pkg::TX_THR_BIT]), .rxEmpty(ev[irq_gate_pkg::RX_EMPTY_BIT]),
    .rxFull(ev[irq_gate_pkg::RX_FULL_BIT]), .rxThreshold(ev[irq_gate_pkg::RX_THR_BIT]),
    .ctrlFull(ev[irq_gate_pkg::CTRL_FULL_BIT]), .ctrlEmpty(ev[irq_gate_pkg::CTRL_EMPTY_BIT]),
    .ctrlThreshold(ev[irq_gate_pkg::CTRL_THR_BIT]),
    .descriptorDone(ev[irq_gate_pkg::DESC_DONE_BIT]),
    .packetDone(ev[irq_gate_pkg::PKT_DONE_BIT]), .dmaBusError(ev[irq_gate_pkg::DMA_ERR_BIT]),
    .moduleIrq(moduleIrq), .statusIrq(statusIrq)
  );

  irq_sink sink (.clk(clk), .reset(reset), .irqLine(moduleIrq), .raiseCount(raiseCount));

  task automatic chkWord(input logic [31:0] exp, input logic [31:0] act, input string what);
    checks++;
    if (act !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, act, exp);
    end
  endtask : chkWord

  task automatic chkBit(input logic exp, input logic act, input string what);
    checks++;
    if (act !== exp) begin
      failures++;
      $display("mismatch at %0t: %s got %b expected %b", $time, what, act, exp);
    end
  endtask : chkBit

  task automatic axiWrite(input logic [11:0] addr, input logic [31:0] data,
                          output logic [1:0] bres);
    logic ta, tw, gotB;
    gotB = 1'b0;
    @(posedge clk);
    awaddr  <= addr;
    wdata   <= data;
    wstrb   <= wrStrbSel;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!gotB) begin
      @(negedge clk);
      ta   = awvalid & awready;
      tw   = wvalid & wready;
      gotB = bvalid;
      bres = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (gotB) bready <= 1'b0;
    end
  endtask : axiWrite

  task automatic axiRead(input logic [11:0] addr, output logic [31:0] data,
                         output logic [1:0] rres);
    logic ta, tr;
    tr = 1'b0;
    @(posedge clk);
    araddr  <= addr;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tr) begin
      @(negedge clk);
      ta   = arvalid & arready;
      tr   = rvalid;
      data = rdata;
      rres = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask : axiRead

  // Events reach status and the registered output on the first edge; the sink counts the rise one edge later.
  task automatic setEv(input logic [11:0] v);
    @(posedge clk);
    ev <= v;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask : setEv

  task automatic conclude();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    conclude();
  end

  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    axiRead(irq_gate_pkg::ENABLE_OFF, rd, resp);
    chkWord(32'h0, rd, "enable after reset");
    chkBit(1'b0, moduleIrq, "irq after reset");
    $display("test reset done");
    axiWrite(irq_gate_pkg::ENABLE_OFF, 32'hffffffff, resp);
    chkWord({30'h0, irq_gate_pkg::RESP_OKAY}, {30'h0, resp}, "write response");
    axiRead(irq_gate_pkg::ENABLE_OFF, rd, resp);
    chkWord(32'h00000fff, rd, "upper enable bits");
    wrStrbSel = 4'h2;
    axiWrite(irq_gate_pkg::ENABLE_OFF, 32'h0, resp);
    wrStrbSel = 4'hf;
    axiRead(irq_gate_pkg::ENABLE_OFF, rd, resp);
    chkWord(32'h000000ff, rd, "byte strobe write");
    $display("test upper bits done");
    base = raiseCount;
    for (int i = 0; i < 12; i++) begin
      axiWrite(irq_gate_pkg::ENABLE_OFF, 32'h1 << i, resp);
      setEv(~(12'h1 << i));
      chkBit(1'b0, moduleIrq, "disabled events blocked");
      setEv(12'h1 << i);
      chkBit(1'b1, moduleIrq, "enabled event passed");
    end
    chkWord({24'h0, base + 8'h0c}, {24'h0, raiseCount}, "interrupts taken");
    $display("test per-bit gating done");
    axiWrite(irq_gate_pkg::ENABLE_OFF, 32'h00000fff, resp);
    setEv(12'h0a5);
    axiRead(irq_gate_pkg::LEVEL_OFF, rd, resp);
    chkWord(32'h000000a5, rd, "live levels");
    setEv(12'h0a4);
    chkBit(1'b1, moduleIrq, "any enabled event");
    axiWrite(irq_gate_pkg::ENABLE_OFF, 32'h00000f5b, resp);
    setEv(12'h0a4);
    chkBit(1'b0, moduleIrq, "only disabled events");
    $display("test or of events done");
    setEv(12'h000);
    axiWrite(irq_gate_pkg::ENABLE_OFF, 32'h00000fff, resp);
    axiWrite(irq_gate_pkg::STATUS_OFF, 32'h00000fff, resp);
    axiWrite(irq_gate_pkg::MASK_OFF, 32'h0, resp);
    setEv(12'h400);
    axiRead(irq_gate_pkg::STATUS_OFF, rd, resp);
    chkWord(32'h00000400, rd, "status sticky bit");
    chkBit(1'b0, statusIrq, "masked status");
    axiWrite(irq_gate_pkg::MASK_OFF, 32'h00000400, resp);
    chkBit(1'b1, statusIrq, "unmasked status");
    setEv(12'h000);
    axiWrite(irq_gate_pkg::STATUS_OFF, 32'h00000400, resp);
    axiRead(irq_gate_pkg::STATUS_OFF, rd, resp);
    chkWord(32'h0, rd, "status cleared");
    chkBit(1'b0, statusIrq, "status irq cleared");
    $display("test status interrupt done");
    axiWrite(12'h010, 32'h1, resp);
    chkWord({30'h0, irq_gate_pkg::RESP_SLVERR}, {30'h0, resp}, "unmapped write");
    axiRead(12'h010, rd, resp);
    chkWord(32'h0, rd, "unmapped read data");
    chkWord({30'h0, irq_gate_pkg::RESP_SLVERR}, {30'h0, resp}, "unmapped read");
    $display("test unmapped done");
    axiWrite(irq_gate_pkg::ENABLE_OFF, 32'h00000fff, resp);
    setEv(12'h001);
    chkBit(1'b1, moduleIrq, "irq before second reset");
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    axiRead(irq_gate_pkg::ENABLE_OFF, rd, resp);
    chkWord(32'h0, rd, "enable after second reset");
    chkBit(1'b0, moduleIrq, "irq after second reset");
    $display("test second reset done");
    conclude();
  end
endmodule : tb
